// file: arws_consts.svh
// Constants of the result word serializer: field positions, codes, timing.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef ARWS_CONSTS_SVH
`define ARWS_CONSTS_SVH
`define ARWS_WORD_BITS 24
`define ARWS_DATA_BITS 20
`define ARWS_BIT_EOC 23
`define ARWS_BIT_CHAN 22
`define ARWS_BIT_SIGN 21
`define ARWS_BIT_EXR 20
`define ARWS_BIT_MSB 19
`define ARWS_CLK_HZ 10000000
`define ARWS_POR_NS 500000
`define ARWS_POR_CYC ((`ARWS_POR_NS / 100) * (`ARWS_CLK_HZ / 10000000))
`define ARWS_CONV_CYC 64
`define ARWS_CODE_HI 20'h1_FFFF
`define ARWS_CODE_LO 20'hE_0000
`define ARWS_SIG_HI 22'h11_FFFF
`define ARWS_SIG_LO 22'h3E_0000
`define ARWS_REF_FULL 22'h0F_FFFF
`endif

// file: arws_pkg.sv
// Types of the result word serializer.
// Needs nothing from outside.
package arws_pkg;
   typedef enum logic [1:0] {
      ARWS_CONVERT = 2'b00,
      ARWS_SLEEP = 2'b01,
      ARWS_OUTPUT = 2'b10
   } arws_state_t;
endpackage

// file: arws_sync.sv
// Three-stage synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
module arws_sync
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic init_in,
   // Signal
   input wire logic async_in,
   output logic level_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk_in)
   begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   // Change taken only when stages two and three agree
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         level_out <= init_in;
      else if (s2_q == s3_q)
         level_out <= s3_q;
   end
endmodule // arws_sync

// file: arws_serializer.sv
// Result word serializer: converts, sleeps and shifts a 24-bit word.
// Assumes chip select and serial clock are pins sampled by clk_in.
// What this block does
// - Each result goes out as a 24-bit word, four status then twenty data.
// - The twenty result bits follow the status bits, most significant first.
// - Bit 23 is end_of_conversion_n, high while converting, low when done.
// - With chip select low in convert or sleep, data pin shows the flag.
// - The flag falls at conversion end without any serial clock edge.
// - Bit 22 is channel_flag, zero for first_input, one for second_input.
// - Bit 21 is sign_flag, high for positive input, low for negative.
// - Bit 20 is range_exceeded_flag, high outside zero to reference.
// - Chip select high floats the data pin and ignores the serial clock.
// - Bit 22 goes out on the first falling edge, then one per fall.
// - Bit 0 leaves on 23rd falling edge; host takes it on 24th rise.
// - The 24th falling edge starts a new conversion and shows its flag.
// - Inputs above 1.125 reference report the 1.125 reference code.
// - Inputs below -0.125 reference report the -0.125 reference code.
// - Supply below about 2.2V holds the block in internal reset.
// - Supply return gives a 0.5ms power-on reset clearing the state, word and pin registers; synchronisers and edge history keep their values.
// - After power-on reset a normal conversion cycle starts at once.
// - Calibration runs in each cycle without changing sequence or timing.
// - Each word belongs to the conversion just done, no pipeline.
// - Output ends after 24 bits or chip select high; conversion follows.
// - Chip select rising during output aborts it and starts conversion.
// - After conversion, sleep holds the result until a rising clock edge.
`timescale 1ns/1ps
`include "arws_consts.svh"
module arws_serializer
   import arws_pkg::*;
#(
   parameter int CONV_CYC = `ARWS_CONV_CYC,
   parameter int POR_CYC = `ARWS_POR_CYC,
   parameter bit TWO_CHANNEL = 1'b1
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Supply monitor, high while supply is below threshold
   input wire logic supply_low_in,
   // Sampled input: signed, in units of result LSB, 22 bits
   input wire logic [21:0] sample_in,
   // Serial link pins
   input wire logic cs_n_in,
   input wire logic sck_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // Status
   output logic converting_out,
   output logic channel_out
);
   logic cs_n_s;
   logic sck_s;
   logic sck_prev_q;
   logic cs_prev_q;
   arws_state_t state_q;
   logic [23:0] word_q;
   logic [4:0] bits_q;
   logic [31:0] conv_cnt_q;
   logic [31:0] por_cnt_q;
   logic por_q;
   logic chan_q;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic reset_int;

   arws_sync u_cs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .init_in(1'b1),
      .async_in(cs_n_in),
      .level_out(cs_n_s)
   );
   arws_sync u_sck (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .init_in(1'b0),
      .async_in(sck_in),
      .level_out(sck_s)
   );

   // Packs the status bits and clamped code of one conversion
   function automatic logic [23:0] arws_pack(input logic [21:0] v,
                                             input logic ch);
      logic sg;
      logic ex;
      logic [21:0] c;
      sg = 1'b0;
      ex = 1'b0;
      c = v;
      if ($signed(v) > $signed(`ARWS_SIG_HI))
         c = `ARWS_SIG_HI;
      else if ($signed(v) < $signed(`ARWS_SIG_LO))
         c = `ARWS_SIG_LO;
      sg = ~c[21];
      ex = c[21] | ($signed(c) > $signed(`ARWS_REF_FULL));
      arws_pack = {1'b0, ch, sg, ex, c[19:0]};
   endfunction

   // Supply loss and power-on pulse both hold the internal reset
   always_ff @(posedge clk_in)
   begin
      if (rst_in || supply_low_in)
      begin
         por_cnt_q <= 32'h0000_0000;
         por_q <= 1'b1;
      end
      else if (por_q)
      begin
         por_cnt_q <= por_cnt_q + 32'h0000_0001;
         if (por_cnt_q >= POR_CYC - 1)
            por_q <= 1'b0;
      end
   end
   assign reset_int = por_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end
      else
      begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
      end
   end
   assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
   assign sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
   assign cs_rise = cs_n_s & ~cs_prev_q;

   // Cycle state machine; calibration hides inside the convert time
   always_ff @(posedge clk_in)
   begin
      if (rst_in || reset_int)
      begin
         state_q <= ARWS_CONVERT;
         conv_cnt_q <= 32'h0000_0000;
         word_q <= 24'h80_0000;
         bits_q <= 5'h0_0;
         chan_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            ARWS_CONVERT:
            begin
               word_q[`ARWS_BIT_EOC] <= 1'b1;
               conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
               if (conv_cnt_q >= CONV_CYC - 1)
               begin
                  word_q <= arws_pack(sample_in, chan_q);
                  state_q <= ARWS_SLEEP;
               end
            end
            ARWS_SLEEP:
            begin
               if (sck_rise)
               begin
                  state_q <= ARWS_OUTPUT;
                  bits_q <= 5'h0_0;
               end
            end
            ARWS_OUTPUT:
            begin
               if (cs_rise)
               begin
                  state_q <= ARWS_CONVERT;
                  conv_cnt_q <= 32'h0000_0000;
                  word_q[`ARWS_BIT_EOC] <= 1'b1;
                  chan_q <= TWO_CHANNEL ? ~chan_q : 1'b0;
               end
               else if (sck_fall)
               begin
                  bits_q <= bits_q + 5'h0_1;
                  word_q <= {word_q[22:0], 1'b1};
                  if (bits_q == 5'd23)
                  begin
                     state_q <= ARWS_CONVERT;
                     conv_cnt_q <= 32'h0000_0000;
                     word_q[`ARWS_BIT_EOC] <= 1'b1;
                     chan_q <= TWO_CHANNEL ? ~chan_q : 1'b0;
                  end
               end
            end
            default:
               state_q <= ARWS_CONVERT;
         endcase
      end
   end

   // Pin drive: flag in convert or sleep, shifted bit in output
   always_ff @(posedge clk_in)
   begin
      if (rst_in || reset_int)
      begin
         sdo_oe_out <= 1'b0;
         sdo_out <= 1'b1;
         converting_out <= 1'b1;
         channel_out <= 1'b0;
      end
      else
      begin
         sdo_oe_out <= ~cs_n_s;
         sdo_out <= word_q[`ARWS_BIT_EOC];
         converting_out <= (state_q == ARWS_CONVERT);
         channel_out <= word_q[`ARWS_BIT_CHAN];
      end
   end

   // Checks
   property p_float;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      cs_n_s |=> !sdo_oe_out;
   endproperty
   a_float: assert property (p_float) else $error("sdo driven, cs high");

   property p_eoc_conv;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_CONVERT) |-> word_q[23];
   endproperty
   a_eoc_conv: assert property (p_eoc_conv) else $error("eoc low");

   property p_done;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_CONVERT && conv_cnt_q >= CONV_CYC - 1)
      |=> state_q == ARWS_SLEEP && !word_q[23];
   endproperty
   a_done: assert property (p_done) else $error("no done");

   property p_sleep_hold;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_SLEEP && !sck_rise) |=> $stable(word_q);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("lost");

   property p_wake;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_SLEEP && sck_rise) |=> state_q == ARWS_OUTPUT;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_abort;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_OUTPUT && cs_rise) |=> state_q == ARWS_CONVERT;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");

   property p_last;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_OUTPUT && sck_fall && !cs_rise && bits_q == 5'd23)
      |=> state_q == ARWS_CONVERT && conv_cnt_q == 0;
   endproperty
   a_last: assert property (p_last) else $error("no restart");

   property p_shift;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_OUTPUT && sck_fall && !cs_rise && bits_q < 5'd23)
      |=> word_q[23] == $past(word_q[22]);
   endproperty
   a_shift: assert property (p_shift) else $error("bad shift");

   property p_range;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_SLEEP) |-> (word_q[21] ? 1'b1 : word_q[20]);
   endproperty
   a_range: assert property (p_range) else $error("exr low");

   property p_clamp;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_SLEEP && word_q[20])
      |-> word_q[19:17] == (word_q[21] ? 3'h0 : 3'h7);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp");

   property p_sleep_flag;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_SLEEP && !cs_n_s) |=> sdo_oe_out && !sdo_out;
   endproperty
   a_sleep_flag: assert property (p_sleep_flag) else $error("eoc");

   property p_conv_len;
      @(posedge clk_in) disable iff (rst_in || reset_int)
      (state_q == ARWS_CONVERT && conv_cnt_q < CONV_CYC - 1)
      |=> state_q == ARWS_CONVERT;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("short");

   // Power-on pulse must run its full length once the supply is back
   property p_por_len;
      @(posedge clk_in) disable iff (rst_in || supply_low_in)
      (por_q && por_cnt_q < POR_CYC - 1) |=> por_q;
   endproperty
   a_por_len: assert property (p_por_len) else $error("por short");

   c_done: cover property (@(posedge clk_in) state_q == ARWS_SLEEP);
   c_out: cover property (@(posedge clk_in) state_q == ARWS_OUTPUT);
   c_abort: cover property (@(posedge clk_in)
      state_q == ARWS_OUTPUT && cs_rise);
   c_clamp: cover property (@(posedge clk_in)
      state_q == ARWS_SLEEP && word_q[20]);
endmodule // arws_serializer

// file: arws_host_model.sv
// Host model: drives chip select and serial clock, reads the data pin.
// Assumes a 10 MHz clk_in; one serial clock period is eight clk cycles.
`timescale 1ns/1ps
module arws_host_model
(
   // Clock
   input wire logic clk_in,
   // Serial link
   input wire logic sdo_in,
   output logic cs_n_out,
   output logic sck_out
);
   initial
   begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Clocks n bits; sel low keeps chip select high throughout
   task automatic frame(input int n, input bit sel, output logic [23:0] w,
      output logic tail, output logic ok);
      int t;
      w = 24'h0;
      t = 0;
      cs_n_out = !sel;
      wait_clk(8);
      while (sel && sdo_in !== 1'b0 && t < 400)
      begin
         wait_clk(1);
         t++;
      end
      ok = (t < 400);
      for (int i = 0; i < n; i++)
      begin
         sck_out = 1'b1;
         w = {w[22:0], sdo_in};
         wait_clk(2);
         sck_out = 1'b0;
         // Data moves about five and a half clocks after the fall
         wait_clk(6);
      end
      wait_clk(4);
      tail = sdo_in;
      cs_n_out = 1'b1;
      wait_clk(2);
   endtask
endmodule // arws_host_model

// file: test_adc_result_word_serializer.sv
// Self-checking bench of the result word serializer.
// Assumes the host model drives the link; clk_in runs at 10 MHz.
`timescale 1ns/1ps
`include "arws_consts.svh"
module test_adc_result_word_serializer;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic supply_low_in = 1'b0;
   logic [21:0] sample_in = 22'h0;
   logic sdo_out, sdo_oe_out, converting_out, channel_out;
   logic cs_n, sck, sdo_wire, tail, ok, exp_ch;
   logic sdo_last_q = 1'b0;
   logic [23:0] w;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   initial
   begin
      forever #50 clk_in = ~clk_in;
   end
   arws_serializer #(.CONV_CYC(20), .POR_CYC(10)) arws_serializer_inst (
      .clk_in(clk_in), .rst_in(rst_in), .supply_low_in(supply_low_in),
      .sample_in(sample_in), .cs_n_in(cs_n), .sck_in(sck),
      .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
      .converting_out(converting_out), .channel_out(channel_out));
   arws_host_model arws_host_model_inst (.clk_in(clk_in),
      .sdo_in(sdo_wire), .cs_n_out(cs_n), .sck_out(sck));
   // Released line shows the inverse of its last driven level
   always @(posedge clk_in)
      if (sdo_oe_out) sdo_last_q <= sdo_out;
   assign sdo_wire = sdo_oe_out ? sdo_out : ~sdo_last_q;
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         summarize();
      end
   end
   function automatic logic [23:0] exp_word(logic [21:0] s, logic ch);
      logic [21:0] c;
      c = s;
      if ($signed(s) > $signed(`ARWS_SIG_HI)) c = `ARWS_SIG_HI;
      if ($signed(s) < $signed(`ARWS_SIG_LO)) c = `ARWS_SIG_LO;
      return {1'b0, ch, ~s[21],
         s[21] | ($signed(s) > $signed(`ARWS_REF_FULL)), c[19:0]};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic read_check;
      arws_host_model_inst.frame(24, 1'b1, w, tail, ok);
      chk({23'h0, ok}, 24'h1);
      chk(w, exp_word(sample_in, exp_ch));
      chk({23'h0, tail}, 24'h1);
      exp_ch = ~exp_ch;
   endtask
   task automatic next(input logic [21:0] s);
      @(negedge clk_in);
      sample_in = s;
   endtask
   initial
   begin
      logic [21:0] corner [8];
      corner = '{22'h12_0000, 22'h11_FFFF, 22'h10_0000, 22'h0F_FFFF,
         22'h00_0000, 22'h3F_FFFF, 22'h2E_0000, 22'h20_0000};
      void'($urandom(32'hcb38b738));
      exp_ch = 1'b0;
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      chk({23'h0, sdo_oe_out}, 24'h0);
      read_check();
      foreach (corner[i])
      begin
         next(corner[i]);
         read_check();
      end
      repeat (10)
      begin
         next(22'($urandom));
         read_check();
      end
      next(22'h05_A5A5);
      repeat (40) @(negedge clk_in);
      chk({23'h0, channel_out}, {23'h0, exp_ch});
      arws_host_model_inst.frame(5, 1'b0, w, tail, ok);
      chk({23'h0, sdo_oe_out}, 24'h0);
      read_check();
      next(22'h0A_BCDE);
      arws_host_model_inst.frame(10, 1'b1, w, tail, ok);
      chk(w, exp_word(sample_in, exp_ch) >> 14);
      exp_ch = ~exp_ch;
      next(22'h01_2345);
      repeat (4) @(negedge clk_in);
      chk({23'h0, converting_out}, 24'h1);
      read_check();
      supply_low_in = 1'b1;
      repeat (10) @(negedge clk_in);
      chk({23'h0, converting_out}, 24'h1);
      chk({23'h0, channel_out}, 24'h0);
      next(22'h07_7777);
      supply_low_in = 1'b0;
      exp_ch = 1'b0;
      // Line floats during the power-on pulse even with chip select low
      repeat (12) @(negedge clk_in);
      read_check();
      next(22'h30_0000);
      read_check();
      summarize();
   end
endmodule // test_adc_result_word_serializer
